/* src/can_tx_pkg.sv */
package can_tx_pkg;

    // Buffer population and history list depth.
    localparam int NUM_BUFFERS = 16;
    localparam logic [2:0] HIST_LAST = 3'h6;
    localparam logic [3:0] ABT_LAST_BUF = 4'h7;
    localparam logic [2:0] TYPE_TRANSMIT = 3'h0;

    // Byte addresses of the global registers.
    localparam logic [8:0] OFS_MODULE_CTRL = 9'h000;
    localparam logic [8:0] OFS_INT_STATUS = 9'h004;
    localparam logic [8:0] OFS_LAST_OUT = 9'h008;
    localparam logic [8:0] OFS_HIST_GET = 9'h00C;

    // Per-buffer register window: base, end and word offsets inside it.
    localparam logic [8:0] OFS_BUF_BASE = 9'h040;
    localparam logic [8:0] OFS_BUF_END = 9'h140;
    localparam logic [3:0] BUF_CFG = 4'h0;
    localparam logic [3:0] BUF_ID = 4'h4;
    localparam logic [3:0] BUF_CTRL = 4'h8;

    // Field positions.
    localparam int CTRL_ABT_BIT = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int CTRL_IRQEN_BIT = 2;
    localparam int CTRL_BUSY_BIT = 3;
    localparam int INT_TXDONE_BIT = 0;
    localparam int HIST_OVF_BIT = 6;
    localparam int HIST_MATCH_BIT = 7;
    localparam int CFG_ASSIGN_BIT = 0;
    localparam int CFG_TYPE_LSB = 1;
    localparam int CFG_IDE_BIT = 4;
    localparam int CFG_RTR_BIT = 5;
    localparam int BCTRL_TRQ_BIT = 0;
    localparam int BCTRL_RDY_BIT = 1;
    localparam int BCTRL_IE_BIT = 2;

    // Zero word that every register read image starts from.
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic {TX_IDLE, TX_ACTIVE} tx_phase_t;

    typedef struct packed {
        logic        buffer_assigned_bit;
        logic [2:0]  buffer_type_field;
        logic        ide;
        logic        rtr;
        logic [28:0] id;
        logic        tx_request_flag;
        logic        rdy;
        logic        buffer_irq_enable;
    } buffer_t;

    typedef struct packed {
        logic        pending;
        logic [3:0]  buffer;
        logic [28:0] ident;
        logic        ide;
        logic        rtr;
    } tx_req_t;

    typedef struct packed {
        logic start;
        logic success;
        logic fail;
    } engine_evt_t;

endpackage

/* src/can_tx_priority_and_history.sv */
`timescale 1ns/1ps
module can_tx_priority_and_history (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [8:0]               adr_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [31:0]              dat_i,
    input  wire can_tx_pkg::engine_evt_t  engine_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,
    output can_tx_pkg::tx_req_t           tx_req_o,
    output logic                          tx_irq_output_o
);

    typedef struct packed {
        can_tx_pkg::buffer_t [15:0] bufs;
        logic                       auto_block_transmit;
        logic                       block_tx_trigger;
        logic                       module_tx_irq_enable;
        logic                       tx_done_status_bit;
        logic [2:0]                 abt_ptr;
        logic [6:0][3:0]            tx_history_list;
        logic [2:0]                 history_write_pointer;
        logic [2:0]                 history_read_pointer;
        logic                       history_pointer_match;
        logic                       history_overflow_flag;
        can_tx_pkg::tx_phase_t      phase;
        can_tx_pkg::tx_req_t        req;
        logic                       irq;
        logic                       ack;
        logic [31:0]                rdata;
    } state_t;

    state_t      st;
    state_t      next;
    logic        best_valid;
    logic [3:0]  best_idx;
    logic [31:0] best_key;
    logic        abt_pending;
    logic        wr_now;
    logic        rd_now;
    logic        in_buf;
    logic [8:0]  boff;
    logic [3:0]  bidx;
    logic [31:0] rimg;
    logic [31:0] wimg;
    logic [31:0] w1c;
    logic        sent_abt;
    logic [2:0]  rp_n;
    logic [2:0]  wp_n;

    // Ordering key: smaller wins. The fields are laid out from the first
    // criterion down so that one unsigned compare does the whole job.
    function automatic logic [31:0] prio_key(input can_tx_pkg::buffer_t b);
        logic std_data;
        std_data = ~b.ide & ~b.rtr;
        prio_key = {b.id[28:18],
                    ~std_data,
                    b.ide,
                    b.ide ? b.id[17:0] : 18'h00000,
                    b.rtr};
    endfunction

    // A buffer takes part in the search only when fully set up for sending.
    function automatic logic eligible(input can_tx_pkg::buffer_t b);
        eligible = b.buffer_assigned_bit && b.rdy && b.tx_request_flag &&
                   (b.buffer_type_field == can_tx_pkg::TYPE_TRANSMIT);
    endfunction

    function automatic logic [2:0] inc_ptr(input logic [2:0] p);
        inc_ptr = (p == can_tx_pkg::HIST_LAST) ? 3'h0 : p + 3'h1;
    endfunction

    function automatic logic [2:0] dec_ptr(input logic [2:0] p);
        dec_ptr = (p == 3'h0) ? can_tx_pkg::HIST_LAST : p - 3'h1;
    endfunction

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Image of one buffer word as software sees it.
    function automatic logic [31:0] buf_word(input can_tx_pkg::buffer_t b,
                                             input logic [3:0] sub);
        buf_word = can_tx_pkg::RESET_WORD;
        case (sub)
            can_tx_pkg::BUF_CFG: begin
                buf_word[can_tx_pkg::CFG_ASSIGN_BIT] = b.buffer_assigned_bit;
                buf_word[can_tx_pkg::CFG_TYPE_LSB +: 3] = b.buffer_type_field;
                buf_word[can_tx_pkg::CFG_IDE_BIT] = b.ide;
                buf_word[can_tx_pkg::CFG_RTR_BIT] = b.rtr;
            end
            can_tx_pkg::BUF_ID: begin
                buf_word[28:0] = b.id;
            end
            can_tx_pkg::BUF_CTRL: begin
                buf_word[can_tx_pkg::BCTRL_TRQ_BIT] = b.tx_request_flag;
                buf_word[can_tx_pkg::BCTRL_RDY_BIT] = b.rdy;
                buf_word[can_tx_pkg::BCTRL_IE_BIT] = b.buffer_irq_enable;
            end
            default: begin
                buf_word = can_tx_pkg::RESET_WORD;
            end
        endcase
    endfunction

    // Address decode and the bus phases. A write and a read side effect
    // happen only at the edge where the master samples ack high.
    assign boff = adr_i - can_tx_pkg::OFS_BUF_BASE;
    assign bidx = boff[7:4];
    assign in_buf = (adr_i >= can_tx_pkg::OFS_BUF_BASE) && (adr_i < can_tx_pkg::OFS_BUF_END);
    assign wr_now = cyc_i && stb_i && st.ack && we_i;
    assign rd_now = cyc_i && stb_i && st.ack && !we_i;
    assign wimg = (rimg & ~byte_mask(sel_i)) | (dat_i & byte_mask(sel_i));
    assign w1c = dat_i & byte_mask(sel_i);
    assign sent_abt = st.auto_block_transmit && (st.req.buffer <= can_tx_pkg::ABT_LAST_BUF);

    // Read image of the addressed register; unmapped words read as zero.
    always_comb begin
        rimg = can_tx_pkg::RESET_WORD;
        if (in_buf) begin
            rimg = buf_word(st.bufs[bidx], boff[3:0]);
        end else begin
            case (adr_i)
                can_tx_pkg::OFS_MODULE_CTRL: begin
                    rimg[can_tx_pkg::CTRL_ABT_BIT] = st.auto_block_transmit;
                    rimg[can_tx_pkg::CTRL_TRIG_BIT] = st.block_tx_trigger;
                    rimg[can_tx_pkg::CTRL_IRQEN_BIT] = st.module_tx_irq_enable;
                    rimg[can_tx_pkg::CTRL_BUSY_BIT] = (st.phase == can_tx_pkg::TX_ACTIVE);
                end
                can_tx_pkg::OFS_INT_STATUS: begin
                    rimg[can_tx_pkg::INT_TXDONE_BIT] = st.tx_done_status_bit;
                end
                can_tx_pkg::OFS_LAST_OUT: begin
                    rimg[3:0] = st.tx_history_list[dec_ptr(st.history_write_pointer)];
                end
                can_tx_pkg::OFS_HIST_GET: begin
                    rimg[3:0] = st.tx_history_list[st.history_read_pointer];
                    rimg[can_tx_pkg::HIST_OVF_BIT] = st.history_overflow_flag;
                    rimg[can_tx_pkg::HIST_MATCH_BIT] = st.history_pointer_match;
                end
                default: begin
                    rimg = can_tx_pkg::RESET_WORD;
                end
            endcase
        end
    end

    // Next-state logic for the whole block.
    always_comb begin
        next = st;
        next.ack = 1'b0;
        next.irq = 1'b0;
        rp_n = st.history_read_pointer;
        wp_n = st.history_write_pointer;
        abt_pending = 1'b0;

        // Strict less-than while walking upward keeps the lowest buffer on a tie.
        best_valid = 1'b0;
        best_idx = 4'h0;
        best_key = '1;
        for (int i = 0; i < can_tx_pkg::NUM_BUFFERS; i++) begin
            if (eligible(st.bufs[i]) &&
                (!best_valid || (prio_key(st.bufs[i]) < best_key))) begin
                best_valid = 1'b1;
                best_idx = 4'(i);
                best_key = prio_key(st.bufs[i]);
            end
        end

        // Answer every request one cycle after it is seen.
        if (cyc_i && stb_i && !st.ack) begin
            next.ack = 1'b1;
            next.rdata = rimg;
        end

        if (wr_now) begin
            if (in_buf) begin
                case (boff[3:0])
                    can_tx_pkg::BUF_CFG: begin
                        next.bufs[bidx].buffer_assigned_bit = wimg[can_tx_pkg::CFG_ASSIGN_BIT];
                        next.bufs[bidx].buffer_type_field = wimg[can_tx_pkg::CFG_TYPE_LSB +: 3];
                        next.bufs[bidx].ide = wimg[can_tx_pkg::CFG_IDE_BIT];
                        next.bufs[bidx].rtr = wimg[can_tx_pkg::CFG_RTR_BIT];
                    end
                    can_tx_pkg::BUF_ID: begin
                        next.bufs[bidx].id = wimg[28:0];
                    end
                    can_tx_pkg::BUF_CTRL: begin
                        // Requests in the block area belong to the sequencer in that mode.
                        if (!(st.auto_block_transmit && bidx <= can_tx_pkg::ABT_LAST_BUF)) begin
                            next.bufs[bidx].tx_request_flag = wimg[can_tx_pkg::BCTRL_TRQ_BIT];
                        end
                        // Software must read ready back: it stays locked mid-frame.
                        if (!(st.phase == can_tx_pkg::TX_ACTIVE && bidx == st.req.buffer)) begin
                            next.bufs[bidx].rdy = wimg[can_tx_pkg::BCTRL_RDY_BIT];
                        end
                        next.bufs[bidx].buffer_irq_enable = wimg[can_tx_pkg::BCTRL_IE_BIT];
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (adr_i)
                    can_tx_pkg::OFS_MODULE_CTRL: begin
                        next.auto_block_transmit = wimg[can_tx_pkg::CTRL_ABT_BIT];
                        next.block_tx_trigger = wimg[can_tx_pkg::CTRL_TRIG_BIT];
                        next.module_tx_irq_enable = wimg[can_tx_pkg::CTRL_IRQEN_BIT];
                    end
                    can_tx_pkg::OFS_INT_STATUS: begin
                        if (w1c[can_tx_pkg::INT_TXDONE_BIT]) begin
                            next.tx_done_status_bit = 1'b0;
                        end
                    end
                    can_tx_pkg::OFS_HIST_GET: begin
                        if (w1c[can_tx_pkg::HIST_OVF_BIT]) begin
                            next.history_overflow_flag = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // A read of the get register consumes one entry unless the list is empty.
        if (rd_now && !in_buf && adr_i == can_tx_pkg::OFS_HIST_GET &&
            !st.history_pointer_match) begin
            rp_n = inc_ptr(st.history_read_pointer);
        end

        // The offer follows the search until the engine starts a frame, then
        // stays frozen so a late winner waits for the next slot.
        case (st.phase)
            can_tx_pkg::TX_IDLE: begin
                if (engine_i.start && st.req.pending) begin
                    next.phase = can_tx_pkg::TX_ACTIVE;
                end else begin
                    next.req.pending = best_valid;
                    next.req.buffer = best_idx;
                    next.req.ident = st.bufs[best_idx].id;
                    next.req.ide = st.bufs[best_idx].ide;
                    next.req.rtr = st.bufs[best_idx].rtr;
                end
            end
            can_tx_pkg::TX_ACTIVE: begin
                if (engine_i.success || engine_i.fail) begin
                    next.phase = can_tx_pkg::TX_IDLE;
                    next.req.pending = 1'b0;
                end
            end
            default: begin
                next.phase = can_tx_pkg::TX_IDLE;
            end
        endcase

        // Completion effects. The status set is applied after any clear above.
        if (st.phase == can_tx_pkg::TX_ACTIVE && engine_i.success) begin
            next.bufs[st.req.buffer].tx_request_flag = 1'b0;
            if (st.bufs[st.req.buffer].buffer_irq_enable) begin
                next.tx_done_status_bit = 1'b1;
                next.irq = st.module_tx_irq_enable;
            end
            if (sent_abt) begin
                if (st.req.buffer == can_tx_pkg::ABT_LAST_BUF) begin
                    next.block_tx_trigger = 1'b0;
                    next.abt_ptr = 3'h0;
                end else begin
                    next.abt_ptr = st.req.buffer[2:0] + 3'h1;
                end
            end else if (st.history_overflow_flag) begin
                // Full: replace the newest entry rather than eat unread ones.
                next.tx_history_list[dec_ptr(st.history_write_pointer)] = st.req.buffer;
            end else begin
                next.tx_history_list[st.history_write_pointer] = st.req.buffer;
                wp_n = inc_ptr(st.history_write_pointer);
                if (wp_n == dec_ptr(rp_n)) begin
                    next.history_overflow_flag = 1'b1;
                end
            end
        end

        next.history_read_pointer = rp_n;
        next.history_write_pointer = wp_n;
        // Pointers only move apart through a real record, so this also keeps
        // the flag set while overflow blocks the write pointer.
        next.history_pointer_match = (wp_n == rp_n);

        // Feed the block area one request at a time.
        for (int j = 0; j <= int'(can_tx_pkg::ABT_LAST_BUF); j++) begin
            abt_pending = abt_pending | next.bufs[j].tx_request_flag;
        end
        if (next.auto_block_transmit && next.block_tx_trigger && !abt_pending) begin
            next.bufs[{1'b0, next.abt_ptr}].tx_request_flag = 1'b1;
        end

        // The list itself is left alone by reset; software must not trust it.
        if (rst_i) begin
            next = '0;
            // Both pointers clear to zero, so the list starts empty and the match flag is set.
            next.history_pointer_match = 1'b1;
            next.tx_history_list = st.tx_history_list;
        end
    end

    // Single state register.
    always_ff @(posedge clk_i) begin
        st <= next;
    end

    assign dat_o = st.rdata;
    assign ack_o = st.ack;
    assign tx_req_o = st.req;
    assign tx_irq_output_o = st.irq;

    a_success_clears_trq: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.phase == can_tx_pkg::TX_ACTIVE && engine_i.success && !sent_abt)
        |=> !st.bufs[$past(st.req.buffer)].tx_request_flag)
        else $error("Request flag not cleared after success.");

    a_irq_needs_enables: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_irq_output_o |-> $past(engine_i.success) && $past(st.module_tx_irq_enable)
            && st.tx_done_status_bit)
        else $error("Interrupt without both enables.");

    a_done_status_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.phase == can_tx_pkg::TX_ACTIVE && engine_i.success &&
         st.bufs[st.req.buffer].buffer_irq_enable) |=> st.tx_done_status_bit)
        else $error("Done status not set.");

    a_match_pointers: assert property (@(posedge clk_i) disable iff (rst_i)
        st.history_pointer_match == (st.history_write_pointer == st.history_read_pointer))
        else $error("Match flag disagrees with pointers.");

    a_ovf_when_full: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.phase == can_tx_pkg::TX_ACTIVE && engine_i.success && !sent_abt &&
         inc_ptr(st.history_write_pointer) == dec_ptr(rp_n)) |=> st.history_overflow_flag)
        else $error("Overflow not flagged on full list.");

    a_ptr_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
        st.history_write_pointer <= can_tx_pkg::HIST_LAST &&
        st.history_read_pointer <= can_tx_pkg::HIST_LAST)
        else $error("History pointer out of range.");

    a_get_advances: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_now && !in_buf && adr_i == can_tx_pkg::OFS_HIST_GET && !st.history_pointer_match)
        |=> st.history_read_pointer == inc_ptr($past(st.history_read_pointer)))
        else $error("Read pointer did not advance.");

    a_offer_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.phase == can_tx_pkg::TX_ACTIVE && !engine_i.success && !engine_i.fail)
        |=> $stable(st.req) [*1])
        else $error("Offer changed during a frame.");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("Ack held longer than one cycle.");

endmodule

/* verification/can_engine_model.sv */
`timescale 1ns/1ps
// Protocol engine stand-in: starts any offered frame and ends it after a short or a long
// gap, so both prompt and slow engines are seen; it fails a frame only when told to.
module can_engine_model (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 hold_i,
    input  wire logic                 fail_i,
    input  wire can_tx_pkg::tx_req_t  tx_req_i,
    output can_tx_pkg::engine_evt_t   evt_o
);
    logic       busy = 1'b0;
    logic       bad  = 1'b0;
    logic [3:0] cnt  = 4'h0;

    // Three idle cycles after a frame let the stale offer drop before the next start.
    always_ff @(posedge clk_i) begin
        evt_o <= '0;
        if (rst_i) begin
            busy <= 1'b0;
            cnt  <= 4'h0;
        end else if (busy && cnt == 4'h0) begin
            busy          <= 1'b0;
            cnt           <= 4'h3;
            evt_o.success <= !bad;
            evt_o.fail    <= bad;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (!hold_i && tx_req_i.pending) begin
            evt_o.start <= 1'b1;
            busy        <= 1'b1;
            bad         <= fail_i;
            cnt         <= {tx_req_i.buffer[0], 3'h2};
        end
    end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic hold = 1'b1, fail = 1'b0, ack_o, tx_irq_output_o;
    logic [8:0] adr_i = 9'h000;
    logic [31:0] dat_i = 32'h0, dat_o;
    can_tx_pkg::engine_evt_t evt;
    can_tx_pkg::tx_req_t tx_req_o;
    logic [63:0] exp_rd[$];
    logic [3:0] exp_tx[$];
    int failures = 0, checks = 0, nsucc = 0, nirq = 0, exp_irq = 0;
    logic [3:0] bufs[7] = '{4'h0, 4'h3, 4'hC, 4'h2, 4'h5, 4'h9, 4'h1};
    logic [1:0] kind[7] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1, 2'h1};
    logic [28:0] ids[7];
    logic [15:0] ie;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

    always #2 clk_i = ~clk_i;

    can_tx_priority_and_history i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
        .engine_i(evt), .dat_o(dat_o), .ack_o(ack_o), .tx_req_o(tx_req_o),
        .tx_irq_output_o(tx_irq_output_o));
    can_engine_model i_eng (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .fail_i(fail),
        .tx_req_i(tx_req_o), .evt_o(evt));

    // One classic cycle; read results are checked by the monitor from the queue.
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        @(posedge clk_i iff ack_o === 1'b1);
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_rd.push_back({m, e});
        wb(1'b0, a, 32'h0);
    endtask
    function automatic logic [8:0] badr(input logic [3:0] m, input logic [3:0] o);
        return can_tx_pkg::OFS_BUF_BASE + {1'b0, m, o};
    endfunction

    // Watches answers, frame starts and interrupt pulses against the notes left by drivers.
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && !we_i) begin
            `CHK(dat_o & exp_rd[0][63:32], exp_rd[0][31:0])
            void'(exp_rd.pop_front());
        end
        if (evt.start === 1'b1) begin
            `CHK(tx_req_o.buffer, exp_tx[0])
            void'(exp_tx.pop_front());
        end
        if (evt.success === 1'b1) nsucc++;
        if (tx_irq_output_o === 1'b1) nirq++;
    end

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // The whole run needs a few hundred cycles; this limit leaves a wide margin.
    initial begin
        #80000;
        failures++;
        stop_test();
    end

    initial begin
        ie = 16'($urandom(32'hD85E));
        ie[1] = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(can_tx_pkg::OFS_HIST_GET, 32'h80, 32'hC0);
        rd(9'h010, 32'h0, 32'hFFFFFFFF);
        wb(1'b1, can_tx_pkg::OFS_MODULE_CTRL, 32'h4);
        // Standard identifiers carry random low bits, which must not affect the order.
        for (int i = 0; i < 7; i++) begin
            ids[i] = {(i == 0) ? 11'h0FF : 11'h100, 18'($urandom)};
            if (kind[i] == 2'h1) ids[i][17:0] = (i == 4) ? 18'h0 : 18'(i - 3);
            wb(1'b1, badr(bufs[i], 4'h0), {26'h0, kind[i], 4'h1});
            wb(1'b1, badr(bufs[i], 4'h4), {3'h0, ids[i]});
            wb(1'b1, badr(bufs[i], 4'h8), {29'h0, ie[bufs[i]], 2'b11});
            if (i > 0) exp_irq += ie[bufs[i]];
        end
        exp_irq += ie[0];
        exp_tx = '{4'h0, 4'h0, 4'h3, 4'hC, 4'h2, 4'h5, 4'h9, 4'h1};
        fail <= 1'b1;
        hold <= 1'b0;
        @(posedge clk_i iff evt.start === 1'b1);
        fail <= 1'b0;
        @(posedge clk_i iff nsucc == 7);
        repeat (3) @(posedge clk_i);
        `CHK(nirq, exp_irq)
        rd(can_tx_pkg::OFS_INT_STATUS, 32'h1, 32'h1);
        rd(badr(4'h1, 4'h8), 32'h6, 32'h7);
        rd(can_tx_pkg::OFS_LAST_OUT, 32'h1, 32'hF);
        // Six unread entries overflow the list; the seventh replaced the newest slot.
        foreach (bufs[i]) if (i != 5) rd(can_tx_pkg::OFS_HIST_GET, {24'h0, 4'h4, bufs[i]},
            32'hCF);
        rd(can_tx_pkg::OFS_HIST_GET, 32'hC0, 32'hC0);
        wb(1'b1, can_tx_pkg::OFS_HIST_GET, 32'h40);
        rd(can_tx_pkg::OFS_HIST_GET, 32'h80, 32'hC0);
        exp_tx.push_back(4'h3);
        wb(1'b1, badr(4'h3, 4'h8), {29'h0, ie[3], 2'b11});
        @(posedge clk_i iff nsucc == 8);
        repeat (3) @(posedge clk_i);
        rd(can_tx_pkg::OFS_LAST_OUT, 32'h3, 32'hF);
        rd(can_tx_pkg::OFS_HIST_GET, 32'h3, 32'hCF);
        // Block mode: software requests in buffers 0-7 are ignored, the sequencer
        // sends them in buffer order, and those frames stay out of the history.
        wb(1'b1, can_tx_pkg::OFS_MODULE_CTRL, 32'h5);
        wb(1'b1, badr(4'h2, 4'h8), {29'h0, ie[2], 2'b11});
        rd(badr(4'h2, 4'h8), {29'h0, ie[2], 2'b10}, 32'h7);
        exp_tx = '{4'h0, 4'h1, 4'h2, 4'h3};
        wb(1'b1, can_tx_pkg::OFS_MODULE_CTRL, 32'h7);
        @(posedge clk_i iff nsucc == 12);
        repeat (3) @(posedge clk_i);
        rd(can_tx_pkg::OFS_LAST_OUT, 32'h3, 32'hF);
        repeat (2) @(posedge clk_i);
        `CHK(exp_rd.size(), 0)
        stop_test();
    end
endmodule
